// file: design/psram_burst_pkg.sv
// Purpose: constants, types and structs of the synchronous burst front end.
// Assumes: 25 MHz host clock, 23-bit word address, 16-bit data.
// Notes: mode word bit positions mirror the configuration address bits.
// What this block does
// - latch address at first clock edge under strobe
// - write strobe level at command picks direction
// - read starts at first edge, strobe low
// - write starts at first edge, both low
// - read data after latency plus one clocks
// - write data sampled after latency minus one
// - first word exact latency, no later waits inserted
// - bursts of 4, 8, 16, 256 words
// - one further read word every clock edge
// - valid indicator with programmable polarity
// - indicator active one clock before each word
// - linear order increments and wraps at length
// - interleave order is start xor beat count
// - all bursts timed from host clock rising edge
// - partial refresh keeps only the chosen region
// - region side taken from array select bit
// - latency code at bits 11 to 9
// - length code at bits 7 to 5, else 16
// - bit 8 selects linear or interleave order; 256 word bursts stay linear
// - bit 13 selects indicator polarity
package psram_burst_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_BITS = 23;
  localparam int DATA_BITS = 16;
  localparam int CNT_BITS = 10;

  // ------------------------------------------------------------
  // mode word layout and reset value
  // ------------------------------------------------------------
  localparam int RET_SIZE_LSB = 0;
  localparam int RET_SIDE_BIT = 2;
  localparam int RET_MODE_LSB = 3;
  localparam int BURST_LEN_LSB = 5;
  localparam int ORDER_BIT = 8;
  localparam int LAT_LSB = 9;
  localparam int POL_BIT = 13;
  localparam logic [1:0] RET_MODE_ON = 2'h2;
  localparam logic [15:0] CFG_RESET = 16'h0098;

  // ------------------------------------------------------------
  // code tables
  // ------------------------------------------------------------
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [2:0] BL_CODE_256 = 3'h7;
  localparam logic [8:0] BL_WORDS_4 = 9'h004;
  localparam logic [8:0] BL_WORDS_8 = 9'h008;
  localparam logic [8:0] BL_WORDS_16 = 9'h010;
  localparam logic [8:0] BL_WORDS_256 = 9'h100;
  localparam logic [2:0] LAT_CODE_MAX = 3'h3;
  localparam logic [3:0] LAT_BASE = 4'h3;
  localparam logic [3:0] READ_EXTRA = 4'h1;
  localparam logic [3:0] WRITE_LESS = 4'h1;
  localparam logic [9:0] REQ_LEAD = 10'h002;

  // ------------------------------------------------------------
  // retention region bounds
  // ------------------------------------------------------------
  localparam logic [22:0] REGION_QTR = 23'h200000;
  localparam logic [22:0] REGION_HALF = 23'h400000;
  localparam logic [22:0] REGION_3QTR = 23'h600000;

  // ------------------------------------------------------------
  // software port map
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } burst_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [22:0] addr;
    logic [15:0] wdata;
    logic retained;
  } mem_req_t;

  typedef struct packed {
    burst_state_t st;
    logic [9:0] cnt;
    logic [3:0] first;
    logic [8:0] len;
    logic [22:0] start;
    logic order;
    logic pol;
    logic [15:0] cfg;
    logic held;
    logic ind;
    logic [15:0] dout;
    logic oe;
    mem_req_t mem;
    logic [15:0] rdata;
  } ctrl_t;

endpackage : psram_burst_pkg

// file: design/psram_sync_burst_interface.sv
// Purpose: synchronous burst read/write front end of a pseudo-static RAM.
// Assumes: host pins synchronous to clk; array answers one cycle after mem.rd.
// Notes: all state is one struct; wait clocks are never inserted by the array.
`timescale 1ns/100ps
module psram_sync_burst_interface
  import psram_burst_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // host pins
  input wire logic sel_n,
  input wire logic address_latch_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_BITS-1:0] addr,
  input wire logic [DATA_BITS-1:0] dq_in,
  output logic [DATA_BITS-1:0] dq_out,
  output logic dq_oe,
  output logic data_valid_ind,
  // array side
  output mem_req_t mem,
  input wire logic [DATA_BITS-1:0] mem_rdata,
  // software port
  input wire reg_req_t reg_req,
  output logic [DATA_BITS-1:0] reg_rdata
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  generate
    if (ADDR_BITS < 9 || CNT_BITS < 10) begin : g_bad_width
      $error("address or counter too narrow for a 256 word burst");
    end
  endgenerate

  ctrl_t q;
  ctrl_t d;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // reserved length codes fall back to 16 words
  function automatic logic [8:0] bl_words(input logic [2:0] code);
    case (code)
      BL_CODE_4: bl_words = BL_WORDS_4;
      BL_CODE_8: bl_words = BL_WORDS_8;
      BL_CODE_16: bl_words = BL_WORDS_16;
      BL_CODE_256: bl_words = BL_WORDS_256;
      default: bl_words = BL_WORDS_16;
    endcase
  endfunction : bl_words

  // edge of first word counted from the command edge
  function automatic logic [3:0] first_edge(input logic [2:0] code, input logic wr);
    logic [3:0] lat;
    lat = (code > LAT_CODE_MAX) ? LAT_BASE : LAT_BASE + {1'b0, code};
    first_edge = wr ? lat - WRITE_LESS : lat + READ_EXTRA;
  endfunction : first_edge

  // word address of one beat inside the wrap window
  function automatic logic [22:0] beat_addr(input logic [22:0] st, input logic [7:0] b,
                                            input logic [8:0] len, input logic ilv);
    logic [7:0] mask;
    logic [7:0] off;
    mask = len[7:0] - 8'h01;
    off = ilv ? (st[7:0] ^ b) : (st[7:0] + b);
    beat_addr = {st[22:8], (st[7:0] & ~mask) | (off & mask)};
  endfunction : beat_addr

  // is this word inside the region that keeps refresh
  function automatic logic in_region(input logic [15:0] cfg, input logic [22:0] a);
    logic [22:0] bound;
    logic top;
    top = cfg[RET_SIDE_BIT];
    case (cfg[RET_SIZE_LSB +: 2])
      2'h1: bound = top ? REGION_QTR : REGION_3QTR;
      2'h2: bound = REGION_HALF;
      2'h3: bound = top ? REGION_3QTR : REGION_QTR;
      default: bound = '0;
    endcase
    if (cfg[RET_MODE_LSB +: 2] != RET_MODE_ON || cfg[RET_SIZE_LSB +: 2] == 2'h0) begin
      in_region = 1'b1;
    end else if (top) begin
      in_region = (a >= bound);
    end else begin
      in_region = (a < bound);
    end
  endfunction : in_region

  // ------------------------------------------------------------
  // command detection
  // ------------------------------------------------------------
  // held blocks extra edges of the same strobe pulse from retriggering
  logic take;
  assign take = (q.st == ST_IDLE) && !sel_n && !address_latch_strobe_n && !q.held;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [9:0] k;
    logic [9:0] fw;
    logic [9:0] lw;
    logic [9:0] rb;
    logic [9:0] db;
    logic act;
    logic ilv;
    k = q.cnt;
    fw = {6'h00, q.first};
    lw = {1'b0, q.len};
    rb = k + REQ_LEAD - fw;
    db = k - fw;
    act = q.pol;
    ilv = q.order && (q.len != BL_WORDS_256); // full page has linear order only
    d = q;
    d.mem.rd = 1'b0;
    d.mem.wr = 1'b0;
    d.rdata = '0;
    // software port: one cycle read latency, unmapped reads as zero
    if (reg_req.wr && reg_req.addr == REG_CFG) begin
      d.cfg = reg_req.wdata;
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_CFG: d.rdata = q.cfg;
        REG_STATUS: d.rdata = {4'h0, q.cnt, q.st == ST_WRITE, q.st != ST_IDLE};
        default: d.rdata = '0;
      endcase
    end
    if (address_latch_strobe_n) begin
      d.held = 1'b0;
    end
    case (q.st)
      ST_IDLE: begin
        d.oe = 1'b0;
        d.ind = ~q.cfg[POL_BIT]; // idle level follows polarity
        if (take) begin
          d.st = write_strobe_n ? ST_READ : ST_WRITE;
          d.start = addr; // first edge under the strobe wins
          d.cnt = 10'h001;
          d.held = 1'b1;
          d.first = first_edge(q.cfg[LAT_LSB +: 3], !write_strobe_n);
          d.len = bl_words(q.cfg[BURST_LEN_LSB +: 3]);
          d.order = q.cfg[ORDER_BIT];
          d.pol = q.cfg[POL_BIT];
        end
      end
      ST_READ, ST_WRITE: begin
        // every step of a burst is one rising edge of clk
        d.cnt = k + 10'h001;
        // indicator leads each word by one clock
        if (k + 10'h001 >= fw && k + 10'h002 <= fw + lw) begin
          d.ind = act;
        end else begin
          d.ind = ~act;
        end
        if (q.st == ST_READ) begin
          // array request two edges ahead of the pin word
          if (k + REQ_LEAD >= fw && k + REQ_LEAD < fw + lw) begin
            d.mem.rd = 1'b1;
            d.mem.addr = beat_addr(q.start, rb[7:0], q.len, ilv);
          end
          if (k >= fw && k < fw + lw) begin
            d.dout = mem_rdata; // one word per edge after the first
            d.oe = 1'b1;
          end else begin
            d.oe = 1'b0;
          end
          if (sel_n) begin
            // deselect stops a read at once, giving short bursts
            d.st = ST_IDLE;
            d.oe = 1'b0;
            d.ind = ~act;
            d.mem.rd = 1'b0;
          end else if (k == fw + lw) begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
          end
        end else begin
          // write data sampled from the first edge of the window
          if (k >= fw && k < fw + lw) begin
            d.mem.wr = 1'b1;
            d.mem.addr = beat_addr(q.start, db[7:0], q.len, ilv);
            d.mem.wdata = dq_in;
          end
          if (k + 10'h001 == fw + lw) begin
            d.st = ST_IDLE;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
        d.oe = 1'b0;
      end
    endcase
    d.mem.retained = in_region(q.cfg, d.mem.addr);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // clk_en low freezes everything, the host then sees a stretched clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cfg <= CFG_RESET;
      q.ind <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign dq_out = q.dout;
  assign dq_oe = q.oe;
  assign data_valid_ind = q.ind;
  assign mem = q.mem;
  assign reg_rdata = q.rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic lat3;
  logic ind_on;
  logic [7:0] wbeat;
  assign lat3 = (q.cfg[LAT_LSB +: 3] == 3'h0);
  assign ind_on = (q.ind == q.pol);
  assign wbeat = q.cnt[7:0] - 8'h01 - {4'h0, q.first};

  sequence s_rd_cmd3;
    take && clk_en && write_strobe_n && lat3;
  endsequence

  sequence s_wr_cmd3;
    take && clk_en && !write_strobe_n && lat3;
  endsequence

  sequence s_rd_keep4;
    (clk_en && !sel_n)[*4];
  endsequence

  a_read_first_word: assert property (@(posedge clk) disable iff (!rst_n)
    s_rd_cmd3 ##1 s_rd_keep4 |-> ##1 $rose(dq_oe))
    else $error("read first word not at latency plus one");

  a_write_first_beat: assert property (@(posedge clk) disable iff (!rst_n)
    s_wr_cmd3 ##1 clk_en[*2] |-> !mem.wr ##1 mem.wr)
    else $error("write first beat not at latency minus one");

  a_ind_leads_data: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dq_oe) |-> $past(ind_on))
    else $error("indicator did not lead read data");

  a_read_stream: assert property (@(posedge clk) disable iff (!rst_n)
    (dq_oe && clk_en && !sel_n && q.cnt < {6'h00, q.first} + {1'b0, q.len}) |=> dq_oe)
    else $error("read stream broke inside burst");

  a_abort_read: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == ST_READ && sel_n && clk_en) |=> (q.st == ST_IDLE) && !dq_oe)
    else $error("deselect did not stop read");

  a_burst_bounded: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st != ST_IDLE) |-> (q.cnt <= {6'h00, q.first} + {1'b0, q.len}))
    else $error("burst ran past its length");

  a_linear_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (mem.wr && $past(mem.wr) && $past(clk_en) && !q.order && q.len == BL_WORDS_4)
      |-> mem.addr[1:0] == $past(mem.addr[1:0]) + 2'h1)
    else $error("linear order did not wrap by one");

  a_interleave_xor: assert property (@(posedge clk) disable iff (!rst_n)
    (mem.wr && q.order && q.len == BL_WORDS_4 && $past(clk_en))
      |-> mem.addr[1:0] == (q.start[1:0] ^ wbeat[1:0]))
    else $error("interleave offset is not start xor beat");

  a_idle_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == ST_IDLE && $past(q.st) == ST_IDLE && $past(clk_en))
      |-> data_valid_ind == ~$past(q.cfg[POL_BIT]))
    else $error("idle indicator at wrong level");

  a_addr_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (take && clk_en) |=> (q.start == $past(addr)) && (q.cnt == 10'h001))
    else $error("address not latched at first edge");

endmodule : psram_sync_burst_interface

// file: test/array_model.sv
// Purpose: behavioural storage array behind the burst front end.
// Assumes: one read pulse per beat, data wanted in the next cycle.
// Notes: only the low 8 address bits select a word, so high regions alias.
`timescale 1ns/100ps
module array_model
  import psram_burst_pkg::*;
(
  // clock
  input wire logic clk,
  // requests from the front end
  input wire mem_req_t mem,
  // read answer
  output logic [DATA_BITS-1:0] mem_rdata
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [DATA_BITS-1:0] store_q [256];

  // preload a pattern that differs from the write pattern
  initial begin
    for (int i = 0; i < 256; i++) begin
      store_q[i] = {i[7:0], ~i[7:0]};
    end
    mem_rdata = '0;
  end

  // stale data is inverted so a late sample cannot look right
  always @(posedge clk) begin
    if (mem.wr) begin
      store_q[mem.addr[7:0]] <= mem.wdata;
    end
    if (mem.rd) begin
      mem_rdata <= store_q[mem.addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : array_model

// file: test/test_psram_sync_burst_interface.sv
// Purpose: directed bursts and register accesses against the front end.
// Assumes: clk_en held high; host side driven by this bench.
// Notes: expected words come from a local image of the array contents.
`timescale 1ns/100ps
module test_psram_sync_burst_interface;
  import psram_burst_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk, rst_n, sel_n, strobe_n, we_n, dq_oe, ind, pol_q, ret_exp;
  logic [22:0] addr;
  logic [15:0] dq_in, dq_out, mem_rdata, reg_rdata;
  logic [15:0] img [256];
  mem_req_t mem;
  reg_req_t reg_req;
  int err_count, total_checks;

  psram_sync_burst_interface uut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .sel_n(sel_n), .address_latch_strobe_n(strobe_n), .write_strobe_n(we_n),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .data_valid_ind(ind),
    .mem(mem), .mem_rdata(mem_rdata), .reg_req(reg_req), .reg_rdata(reg_rdata));
  array_model model (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------
  // report and compare
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk16

  task automatic chk1(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %b seen %b", what, exp, got);
      err_count++;
    end
  endtask : chk1

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  task automatic reg_wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask : reg_wr

  task automatic reg_rd(logic [3:0] a, logic [15:0] exp, string what);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    reg_req <= '0;
    @(negedge clk);
    chk16(what, exp, reg_rdata);
  endtask : reg_rd

  // mode word: polarity, latency code, order, length code, retention bits
  task automatic cfg(logic [2:0] lat, logic [2:0] bl, logic ilv, logic pol, logic [4:0] ret);
    pol_q = pol;
    reg_wr(REG_CFG, {2'h0, pol, 1'b0, lat, ilv, bl, ret});
  endtask : cfg

  function automatic logic [22:0] beat(logic [22:0] s, int len, logic ilv, int b);
    logic [22:0] m;
    m = 23'(len - 1);
    if (ilv && len != 256) begin
      return s ^ 23'(b);
    end
    return (s & ~m) | ((s + 23'(b)) & m);
  endfunction : beat

  // ------------------------------------------------------------
  // one burst; stop_k > 0 raises select after that edge
  // ------------------------------------------------------------
  task automatic burst(logic wr, logic [22:0] s, int lat, int len, logic ilv, int stop_k);
    int f;
    logic [22:0] a;
    f = wr ? lat - 1 : lat + 1;
    @(posedge clk);
    sel_n <= 1'b0;
    strobe_n <= 1'b0;
    we_n <= ~wr;
    addr <= s;
    @(posedge clk);
    strobe_n <= 1'b1;
    // no new command until this loop has run out
    for (int k = 1; k <= f + len; k++) begin
      @(posedge clk);
      if (wr && k >= f - 1 && k <= f + len - 2) begin
        a = beat(s, len, ilv, k + 1 - f);
        dq_in <= {~a[7:0], a[7:0]};
        img[a[7:0]] = {~a[7:0], a[7:0]};
      end
      if (k == stop_k) begin
        sel_n <= 1'b1;
      end
      @(negedge clk);
      if (stop_k > 0 && k == stop_k + 1) begin
        chk1("oe after stop", 1'b0, dq_oe);
        break;
      end
      if (!wr && k >= f && k < f + len) begin
        a = beat(s, len, ilv, k - f);
        chk1("oe in window", 1'b1, dq_oe);
        chk16("read word", img[a[7:0]], dq_out);
      end
      if (!wr && k == f + len) begin
        chk1("oe after burst", 1'b0, dq_oe);
      end
      chk1("indicator", (k >= f - 1 && k <= f + len - 2) ? pol_q : ~pol_q, ind);
      if (mem.rd === 1'b1) begin
        chk1("retained", ret_exp, mem.retained);
      end
    end
  endtask : burst

  // watchdog
  initial begin
    #400000;
    err_count++;
    stop_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    sel_n = 1'b1;
    strobe_n = 1'b1;
    we_n = 1'b1;
    addr = '0;
    dq_in = '0;
    reg_req = '0;
    pol_q = 1'b0;
    ret_exp = 1'b1;
    err_count = 0;
    total_checks = 0;
    for (int i = 0; i < 256; i++) begin
      img[i] = {i[7:0], ~i[7:0]};
    end
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk1("indicator at reset", 1'b1, ind);
    chk1("oe at reset", 1'b0, dq_oe);
    reg_rd(REG_CFG, CFG_RESET, "mode word reset");
    burst(1'b0, 23'h000001, 3, 16, 1'b0, 0);
    cfg(3'h0, BL_CODE_4, 1'b0, 1'b0, 5'h18);
    burst(1'b0, 23'h000001, 3, 4, 1'b0, 0);
    burst(1'b0, 23'h000003, 3, 4, 1'b0, 0);
    // a short linear write wraps inside its window before it is read back
    burst(1'b1, 23'h000061, 3, 4, 1'b0, 0);
    burst(1'b0, 23'h000061, 3, 4, 1'b0, 0);
    cfg(3'h0, BL_CODE_4, 1'b1, 1'b0, 5'h18);
    burst(1'b0, 23'h000001, 3, 4, 1'b1, 0);
    burst(1'b0, 23'h000003, 3, 4, 1'b1, 0);
    // an interleaved write lands at start xor beat
    burst(1'b1, 23'h00006B, 3, 4, 1'b1, 0);
    burst(1'b0, 23'h00006B, 3, 4, 1'b1, 0);
    // latency codes 0 to 3 at 8 words, interleaved; the host keeps to its clock
    for (int c = 0; c < 4; c++) begin
      cfg(3'(c), BL_CODE_8, 1'b1, 1'b0, 5'h18);
      burst(1'b0, 23'h000025, c + 3, 8, 1'b1, 0);
    end
    cfg(3'h5, BL_CODE_8, 1'b0, 1'b0, 5'h18);
    burst(1'b0, 23'h000025, 3, 8, 1'b0, 0);
    cfg(3'h1, BL_CODE_8, 1'b0, 1'b0, 5'h18);
    burst(1'b1, 23'h00002E, 4, 8, 1'b0, 0);
    burst(1'b0, 23'h00002E, 4, 8, 1'b0, 0);
    cfg(3'h0, BL_CODE_16, 1'b1, 1'b1, 5'h18);
    burst(1'b1, 23'h000047, 3, 16, 1'b1, 0);
    burst(1'b0, 23'h000047, 3, 16, 1'b1, 0);
    cfg(3'h0, BL_CODE_256, 1'b0, 1'b0, 5'h18);
    burst(1'b0, 23'h0000FA, 3, 256, 1'b0, 46);
    cfg(3'h0, 3'h1, 1'b1, 1'b0, 5'h18);
    burst(1'b0, 23'h000005, 3, 16, 1'b1, 0);
    // half of the array retained, bottom then top
    cfg(3'h0, BL_CODE_4, 1'b0, 1'b0, 5'h12);
    burst(1'b0, 23'h000010, 3, 4, 1'b0, 0);
    ret_exp = 1'b0;
    burst(1'b0, 23'h400010, 3, 4, 1'b0, 0);
    cfg(3'h0, BL_CODE_4, 1'b0, 1'b0, 5'h16);
    burst(1'b0, 23'h000010, 3, 4, 1'b0, 0);
    ret_exp = 1'b1;
    burst(1'b0, 23'h400010, 3, 4, 1'b0, 0);
    reg_wr(4'hF, 16'hFFFF);
    reg_rd(4'hF, 16'h0000, "unmapped read");
    stop_test();
  end
endmodule : test_psram_sync_burst_interface
